//--- verilog/asf_pkg.sv
// package: constants and types of the serial frame sequencer
package asf_pkg;
	// command word fields
	localparam int unsigned MODE_MSB   = 15;
	localparam int unsigned MODE_LSB   = 12;
	localparam int unsigned UPD_BIT    = 11;
	localparam int unsigned CH_MSB     = 10;
	localparam int unsigned CH_LSB     = 7;
	localparam int unsigned RANGE_BIT  = 6;
	localparam int unsigned PD_BIT     = 5;
	localparam int unsigned STAT_BIT   = 4;
	localparam int unsigned LAST_MSB   = 9;
	localparam int unsigned LAST_LSB   = 6;
	localparam int unsigned THR_SEL    = 11;
	// command codes in the mode field
	localparam logic [3:0] CMD_MANUAL  = 4'h1;
	localparam logic [3:0] CMD_AUTO1   = 4'h2;
	localparam logic [3:0] CMD_AUTO2   = 4'h3;
	localparam logic [3:0] CMD_AUX     = 4'h4;
	localparam logic [3:0] CMD_MAP     = 4'h8;
	localparam logic [3:0] CMD_LAST    = 4'h9;
	localparam logic [3:0] CMD_ALARM   = 4'hC;
	// aux configuration bits
	localparam int unsigned AUX_ALM    = 4;
	localparam int unsigned AUX_PD     = 5;
	// reset values
	localparam logic [7:0] MAP_RST     = 8'hFF;
	localparam logic [3:0] LAST_RST    = 4'h7;
	localparam logic [3:0] CH_RST      = 4'h0;
	localparam logic [7:0] HI_THR_RST  = 8'hFF;
	localparam logic [7:0] LO_THR_RST  = 8'h00;
	localparam logic [5:0] AUX_RST     = 6'h00;
	// edge numbers within a frame
	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [4:0] CH_FALL     = 5'h02;
	localparam logic [4:0] ALM_CLR     = 5'h0A;
	localparam logic [4:0] ALM_SET     = 5'h0C;
	localparam logic [4:0] ACQ_RISE    = 5'h0E;
	typedef enum logic [1:0] {SEQ_MANUAL, SEQ_AUTO1, SEQ_AUTO2} asf_mode_type;
endpackage

//--- verilog/asf_seq_if.sv
// interface: frame logic to channel sequencer
`timescale 1ns/10ps
interface asf_seq_if;
	logic                  step;
	logic                  wr_mode;
	asf_pkg::asf_mode_type mode;
	logic                  wr_map;
	logic [7:0]            map_data;
	logic                  wr_last;
	logic [3:0]            last_data;
	logic [3:0]            manual_ch;
	logic                  clr_prog;
	logic [3:0]            cur_ch;
	modport frm (output step, wr_mode, mode, wr_map, map_data, wr_last, last_data,
		manual_ch, clr_prog, input cur_ch);
	modport seq (input step, wr_mode, mode, wr_map, map_data, wr_last, last_data,
		manual_ch, clr_prog, output cur_ch);
endinterface

//--- verilog/asf_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module asf_sync #(
	parameter int unsigned W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			meta_ff <= RST;
			q_o     <= RST;
		end
		else
		begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule // asf_sync

//--- verilog/asf_chan_seq.sv
// channel sequencer: mode, scan program registers and current channel
`timescale 1ns/10ps
module asf_chan_seq (
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// frame side
	asf_seq_if.seq   sq
);
	asf_pkg::asf_mode_type mode_ff;
	logic [7:0]            map_ff;
	logic [3:0]            last_ff;
	logic [3:0]            ch_ff;

	// next enabled channel above cur, wrapping; an empty map holds the channel
	function automatic logic [3:0] next_mapped(input logic [3:0] cur, input logic [7:0] map);
		logic [3:0] res;
		logic [3:0] idx;
		res = cur;
		for (int i = 7; i >= 1; i--)
		begin
			idx = (cur + 4'(i)) & 4'h7;
			if (map[idx[2:0]])
				res = idx;
		end
		return res;
	endfunction

	assign sq.cur_ch = ch_ff;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			mode_ff <= asf_pkg::SEQ_MANUAL; // [R17]
		else if (sq.wr_mode)
			mode_ff <= sq.mode;
	end

	// program registers survive mode changes, cleared only by reset and power-down
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			map_ff  <= asf_pkg::MAP_RST; // [R20]
			last_ff <= asf_pkg::LAST_RST; // [R22]
		end
		else if (sq.clr_prog)
		begin
			map_ff  <= asf_pkg::MAP_RST; // [R19]
			last_ff <= asf_pkg::LAST_RST;
		end
		else
		begin
			if (sq.wr_map)
				map_ff <= sq.map_data;
			if (sq.wr_last)
				last_ff <= sq.last_data;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ch_ff <= asf_pkg::CH_RST; // [R17]
		else if (sq.step)
		begin
			unique case (mode_ff)
				asf_pkg::SEQ_MANUAL: ch_ff <= sq.manual_ch; // [R16]
				asf_pkg::SEQ_AUTO1:  ch_ff <= next_mapped(ch_ff, map_ff); // [R18]
				asf_pkg::SEQ_AUTO2:  ch_ff <= (ch_ff >= last_ff) ? 4'h0 : ch_ff + 4'h1; // [R21]
			endcase
		end
	end

	chk_manual_channel: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R16]
		sq.step && mode_ff == asf_pkg::SEQ_MANUAL |=> ch_ff == $past(sq.manual_ch))
		else $error("manual channel not taken");
	chk_auto2_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R21]
		sq.step && mode_ff == asf_pkg::SEQ_AUTO2 && ch_ff >= last_ff |=> ch_ff == 4'h0)
		else $error("last-channel scan did not wrap");
endmodule // asf_chan_seq

//--- verilog/asf_frame_top.sv
// top: serial frame engine, settings, alarms and power-down
`timescale 1ns/10ps
// Notes on behaviour
// [R1] chip select fall samples, starts conversion
// [R2] sixteen bits out: address then result
// [R3] input status replaces address when requested
// [R4] multiplexer switches on second clock fall
// [R5] acquisition from rise fourteen to select
// [R6] outputs refresh at select fall
// [R7] address then result on falls one-thirteen
// [R8] sixteenth fall releases output, ends conversion
// [R9] command bits taken on every rise
// [R10] host holds select for sixteen clocks
// [R11] alarm raised on twelfth fall
// [R12] alarm cleared tenth fall next frame
// [R13] power-down bit acts sixteenth fall next
// [R14] powerdown pin low powers down at once
// [R15] wake at select fall when allowed
// [R16] manual channel used next frame
// [R17] reset gives manual mode, channel zero
// [R18] bitmap scan ascends enabled channels
// [R19] scan programs kept across mode changes
// [R20] bitmap resets to all ones
// [R21] last-channel scan wraps to zero
// [R22] last channel resets to seven
// [R23] code 0001 selects manual mode
// [R24] update enable gates lower settings
// [R25] four-bit next channel, MSB first
// [R26] range bit picks doubled range
// [R27] two zero bits after result
// [R28] programming never stalls conversions
module asf_frame_top (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	// serial link
	input  wire logic       cs_n_i,
	input  wire logic       sclk_i,
	input  wire logic       sdi_i,
	output logic            sdo_o,
	output logic            sdo_oe_n_o,
	// converter core
	input  wire logic [9:0] conv_data_i,
	output logic            sample_o,
	output logic            conv_busy_o,
	output logic            acq_o,
	output logic [3:0]      mux_ch_o,
	output logic            range_o,
	output logic            pwrdn_o,
	// aux pins
	input  wire logic [3:0] aux_in_i,
	output logic [3:0]      aux_out_o,
	output logic [3:0]      aux_oe_n_o
);
	// ==========================================================
	// pin sampling and edges
	logic [6:0]  sync_q;
	logic        s_cs_n;
	logic        s_sclk;
	logic        s_sdi;
	logic [3:0]  s_aux;
	logic        d_cs_ff;
	logic        d_sclk_ff;
	logic        cs_fall;
	logic        sclk_fall;
	logic        sclk_rise;

	// serial clock idles low between frames, so its sampled copy resets low as well
	asf_sync #(.W(7), .RST(7'h01)) u_sync (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.d_i       ({aux_in_i, sdi_i, sclk_i, cs_n_i}),
		.q_o       (sync_q)
	);
	assign {s_aux, s_sdi, s_sclk, s_cs_n} = sync_q;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			d_cs_ff   <= 1'b1;
			d_sclk_ff <= 1'b0;
		end
		else
		begin
			d_cs_ff   <= s_cs_n;
			d_sclk_ff <= s_sclk;
		end
	end
	assign cs_fall   = d_cs_ff & ~s_cs_n;
	assign sclk_fall = ~s_cs_n & d_sclk_ff & ~s_sclk;
	assign sclk_rise = ~s_cs_n & ~d_sclk_ff & s_sclk;

	// ==========================================================
	// edge counters and command capture
	logic [4:0]  fall_cnt_ff;
	logic [4:0]  rise_cnt_ff;
	logic [15:0] cmd_sh_ff;
	logic [15:0] nxt_cmd;
	logic        cmd_done;
	logic [4:0]  fall_num;

	assign fall_num = fall_cnt_ff + 5'h01;
	assign nxt_cmd  = {cmd_sh_ff[14:0], s_sdi};
	// the host must not raise select early; a short frame is simply discarded
	assign cmd_done = sclk_rise && rise_cnt_ff == asf_pkg::FRAME_EDGES - 5'h01; // [R10]

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			fall_cnt_ff <= 5'h00;
			rise_cnt_ff <= 5'h00;
			cmd_sh_ff   <= 16'h0000;
		end
		else if (cs_fall)
		begin
			fall_cnt_ff <= 5'h00;
			rise_cnt_ff <= 5'h00;
		end
		else
		begin
			if (sclk_fall && fall_cnt_ff < asf_pkg::FRAME_EDGES)
				fall_cnt_ff <= fall_num;
			if (sclk_rise && rise_cnt_ff < asf_pkg::FRAME_EDGES)
			begin
				rise_cnt_ff <= rise_cnt_ff + 5'h01;
				cmd_sh_ff   <= nxt_cmd; // [R9]
			end
		end
	end

	// ==========================================================
	// command decode
	function automatic logic is_seq_cmd(input logic [3:0] code);
		return code == asf_pkg::CMD_MANUAL || code == asf_pkg::CMD_AUTO1 ||
			code == asf_pkg::CMD_AUTO2;
	endfunction

	logic [3:0]  cmd_code;
	logic [5:0]  aux_cfg_ff;
	logic [3:0]  manual_ch_ff;
	logic        range_pend_ff;
	logic        pd_pend_ff;
	logic        stat_pend_ff;
	logic [3:0]  outd_pend_ff;
	logic [7:0]  hi_thr_ff [8];
	logic [7:0]  lo_thr_ff [8];
	asf_seq_if   sq ();

	assign cmd_code = nxt_cmd[asf_pkg::MODE_MSB:asf_pkg::MODE_LSB];

	asf_chan_seq u_seq (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.sq        (sq)
	);

	// settings land at frame end and take effect in the next frame, except the aux configuration, which acts at once
	assign sq.wr_mode   = cmd_done && is_seq_cmd(cmd_code); // [R28]
	assign sq.mode      = (cmd_code == asf_pkg::CMD_MANUAL) ? asf_pkg::SEQ_MANUAL : // [R23]
		(cmd_code == asf_pkg::CMD_AUTO1) ? asf_pkg::SEQ_AUTO1 : asf_pkg::SEQ_AUTO2;
	assign sq.wr_map    = cmd_done && cmd_code == asf_pkg::CMD_MAP;
	assign sq.map_data  = nxt_cmd[7:0];
	assign sq.wr_last   = cmd_done && cmd_code == asf_pkg::CMD_LAST;
	assign sq.last_data = nxt_cmd[asf_pkg::LAST_MSB:asf_pkg::LAST_LSB];
	assign sq.manual_ch = manual_ch_ff;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			manual_ch_ff  <= asf_pkg::CH_RST;
			range_pend_ff <= 1'b0;
			pd_pend_ff    <= 1'b0;
			stat_pend_ff  <= 1'b0;
			outd_pend_ff  <= 4'h0;
		end
		else if (cmd_done && is_seq_cmd(cmd_code))
		begin
			manual_ch_ff <= nxt_cmd[asf_pkg::CH_MSB:asf_pkg::CH_LSB]; // [R25]
			if (nxt_cmd[asf_pkg::UPD_BIT]) // [R24]
			begin
				range_pend_ff <= nxt_cmd[asf_pkg::RANGE_BIT]; // [R26]
				pd_pend_ff    <= nxt_cmd[asf_pkg::PD_BIT];
				stat_pend_ff  <= nxt_cmd[asf_pkg::STAT_BIT];
				outd_pend_ff  <= nxt_cmd[3:0];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			aux_cfg_ff <= asf_pkg::AUX_RST;
			for (int i = 0; i < 8; i++)
			begin
				hi_thr_ff[i] <= asf_pkg::HI_THR_RST;
				lo_thr_ff[i] <= asf_pkg::LO_THR_RST;
			end
		end
		else if (cmd_done && cmd_code == asf_pkg::CMD_AUX)
			aux_cfg_ff <= nxt_cmd[5:0];
		else if (cmd_done && cmd_code == asf_pkg::CMD_ALARM)
		begin
			if (nxt_cmd[asf_pkg::THR_SEL])
				hi_thr_ff[nxt_cmd[10:8]] <= nxt_cmd[7:0];
			else
				lo_thr_ff[nxt_cmd[10:8]] <= nxt_cmd[7:0];
		end
	end

	// ==========================================================
	// power-down
	logic        pd_pin_low;
	logic        wake_ok;
	logic        go;
	logic        pd_enter;
	logic        pd_act_ff;

	assign pd_pin_low = aux_cfg_ff[asf_pkg::AUX_PD] & ~s_aux[3];
	assign wake_ok    = ~pd_pend_ff & ~pd_pin_low; // [R15]
	assign go         = cs_fall & (~pwrdn_o | wake_ok);
	assign pd_enter   = ~pwrdn_o & (pd_pin_low | // [R14]
		(sclk_fall && fall_num == asf_pkg::FRAME_EDGES && pd_act_ff)); // [R13]
	assign sq.clr_prog = pd_enter;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			pwrdn_o <= 1'b0;
		else if (pd_enter)
			pwrdn_o <= 1'b1;
		else if (pwrdn_o && cs_fall && wake_ok)
			pwrdn_o <= 1'b0; // [R15]
	end

	// ==========================================================
	// frame engine
	logic        act_ff;
	logic [15:0] out_sh_ff;
	logic [9:0]  result_ff;
	logic [3:0]  frm_ch_ff;
	logic [15:0] out_word;

	assign out_word = {stat_pend_ff ? s_aux : sq.cur_ch, conv_data_i, 2'b00}; // [R2] [R3] [R27]
	assign sq.step  = act_ff && sclk_fall && fall_num == asf_pkg::CH_FALL; // [R4]

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			act_ff      <= 1'b0;
			sample_o    <= 1'b0;
			conv_busy_o <= 1'b0;
			sdo_o       <= 1'b0;
			sdo_oe_n_o  <= 1'b1;
			out_sh_ff   <= 16'h0000;
			result_ff   <= 10'h000;
			frm_ch_ff   <= 4'h0;
			range_o     <= 1'b0;
			pd_act_ff   <= 1'b0;
		end
		else
		begin
			sample_o <= go; // [R1]
			if (go)
			begin
				act_ff      <= 1'b1;
				conv_busy_o <= 1'b1; // [R1]
				out_sh_ff   <= out_word;
				sdo_o       <= out_word[15]; // [R7]
				sdo_oe_n_o  <= 1'b0;
				result_ff   <= conv_data_i;
				frm_ch_ff   <= sq.cur_ch;
				range_o     <= range_pend_ff; // [R26]
				// the request is decoded at rise sixteen, before fall sixteen of its own frame
				pd_act_ff   <= pd_pend_ff; // [R13]
			end
			else if (pd_enter || (act_ff && sclk_fall && fall_num == asf_pkg::FRAME_EDGES))
			begin
				act_ff      <= 1'b0;
				conv_busy_o <= 1'b0; // [R8]
				sdo_oe_n_o  <= 1'b1;
			end
			else if (act_ff && sclk_fall)
				sdo_o <= out_sh_ff[4'(5'h0F - fall_num)]; // [R7]
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			acq_o <= 1'b0;
		else if (cs_fall)
			acq_o <= 1'b0; // [R5]
		else if (act_ff && sclk_rise && rise_cnt_ff == asf_pkg::ACQ_RISE - 5'h01)
			acq_o <= 1'b1; // [R5]
	end

	// ==========================================================
	// alarms and aux pins
	logic        alm_hi_ff;
	logic        alm_lo_ff;
	logic [3:0]  outd_ff;
	logic        alm_en;

	assign alm_en = aux_cfg_ff[asf_pkg::AUX_ALM];

	// the clear on fall ten always precedes a new raise on fall twelve
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			alm_hi_ff <= 1'b0;
			alm_lo_ff <= 1'b0;
		end
		else if (act_ff && sclk_fall && fall_num == asf_pkg::ALM_CLR)
		begin
			alm_hi_ff <= 1'b0; // [R12]
			alm_lo_ff <= 1'b0;
		end
		else if (act_ff && sclk_fall && fall_num == asf_pkg::ALM_SET)
		begin
			alm_hi_ff <= result_ff[9:2] > hi_thr_ff[frm_ch_ff[2:0]]; // [R11]
			alm_lo_ff <= result_ff[9:2] < lo_thr_ff[frm_ch_ff[2:0]];
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			outd_ff <= 4'h0;
		else if (go)
			outd_ff <= outd_pend_ff; // [R6]
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			aux_out_o  <= 4'h0;
			aux_oe_n_o <= 4'hF;
			mux_ch_o   <= asf_pkg::CH_RST;
		end
		else
		begin
			aux_out_o  <= {outd_ff[3:2], alm_en ? alm_lo_ff : outd_ff[1],
				alm_en ? alm_hi_ff : outd_ff[0]};
			aux_oe_n_o <= {~aux_cfg_ff[3] | aux_cfg_ff[asf_pkg::AUX_PD], ~aux_cfg_ff[2],
				~(aux_cfg_ff[1] | alm_en), ~(aux_cfg_ff[0] | alm_en)};
			mux_ch_o   <= sq.cur_ch; // [R4]
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	chk_frame_start: assert property (go |=> sample_o && conv_busy_o && !sdo_oe_n_o) // [R1]
		else $error("frame start missed");
	chk_sdo_first: assert property (go |=> sdo_o == $past(out_word[15])) // [R7]
		else $error("first output bit wrong");
	chk_sdo_release: assert property (act_ff && sclk_fall && fall_num == 5'h10 // [R8]
		|=> sdo_oe_n_o && !conv_busy_o) else $error("output not released");
	chk_acq_start: assert property (act_ff && sclk_rise && rise_cnt_ff == 5'h0D // [R5]
		|=> acq_o) else $error("acquisition late");
	chk_alarm_clear: assert property (act_ff && sclk_fall && fall_num == 5'h0A // [R12]
		|=> !alm_hi_ff && !alm_lo_ff) else $error("alarm not cleared");
	chk_pd_entry: assert property (act_ff && sclk_fall && fall_num == 5'h10 && pd_act_ff // [R13]
		|=> pwrdn_o) else $error("power-down late");
	chk_outd_refresh: assert property (go && !alm_en ##2 !alm_en // [R6]
		|-> aux_out_o == $past(outd_pend_ff, 2)) else $error("outputs not refreshed");
	chk_chan_step: assert property (sq.step |=> ##1 mux_ch_o == sq.cur_ch) // [R4]
		else $error("multiplexer not updated");
endmodule // asf_frame_top

//--- sim/asf_host_model.sv
// host model: serial master that runs one sixteen-clock frame and records what it sees
`timescale 1ns/10ps
module asf_host_model (
	// clock
	input  wire logic       mclk_i,
	// serial link
	output logic            cs_n_o,
	output logic            sclk_o,
	output logic            sdi_o,
	input  wire logic       sdo_i,
	input  wire logic       sdo_oe_n_i,
	// observed outputs, sampled at each clock fall
	input  wire logic [7:0] probe_i
);
	logic [7:0]  pv [16];
	logic [15:0] rx;
	logic        oe_bad;

	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
	end

	// ==========================================
	// frame
	// clock idles low between frames; sdi shows the inverse of its last bit when idle
	task automatic frame(input logic [15:0] cmd);
		oe_bad = 1'b0;
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
		for (int k = 15; k >= 0; k--)
		begin
			sdi_o <= cmd[k];
			repeat (4) @(posedge mclk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			// values seen here were launched a full clock period earlier
			rx[k]     = sdo_i;
			oe_bad    = oe_bad | sdo_oe_n_i;
			pv[15-k]  = probe_i;
			sclk_o   <= 1'b0;
		end
		repeat (4) @(posedge mclk_i);
		cs_n_o <= 1'b1;
		sdi_o  <= ~cmd[0];
		repeat (8) @(posedge mclk_i);
	endtask
endmodule // asf_host_model

//--- sim/testbench.sv
// testbench: host frames against the frame engine, with a channel and settings model
`timescale 1ns/10ps
module testbench;
	logic        mclk_i;
	logic        sys_rst_i;
	logic        cs_n;
	logic        sclk;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe_n;
	logic [9:0]  conv_data;
	logic        sample;
	logic        busy;
	logic        acq;
	logic [3:0]  mux_ch;
	logic        rng;
	logic        pwrdn;
	logic [3:0]  aux_in;
	logic [3:0]  aux_out;
	logic [3:0]  aux_oe_n;
	int          failures;
	int          compares;
	int          scount;
	logic [3:0]  cur, man_p, mode_p, mode_a, last_r, aux_p, aux_a, pin_mask, a;
	logic [7:0]  map_r;
	logic        rng_p, rng_a, st_p, st_a, lax;

	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i)
		if (sample === 1'b1)
			scount <= scount + 1;

	asf_frame_top dut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .conv_data_i(conv_data), .sample_o(sample),
		.conv_busy_o(busy), .acq_o(acq), .mux_ch_o(mux_ch), .range_o(rng), .pwrdn_o(pwrdn),
		.aux_in_i(aux_in), .aux_out_o(aux_out), .aux_oe_n_o(aux_oe_n)
	);

	asf_host_model host (
		.mclk_i(mclk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
		.sdo_oe_n_i(sdo_oe_n), .probe_i({mux_ch, pwrdn, acq, busy, aux_out[0]})
	);

	// ==========================================
	// checking
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// channel the sequencer should pick at the second clock fall
	function automatic logic [3:0] next_ch(input logic [3:0] c);
		logic [3:0] n;
		n = c;
		if (mode_a == 4'h1)
			n = man_p;
		else if (mode_a == 4'h2)
			for (int i = 8; i >= 1; i--)
				if (map_r[(c + i) % 8])
					n = 4'((c + i) % 8);
		if (mode_a == 4'h3)
			n = (c >= last_r) ? 4'h0 : c + 4'h1;
		return n;
	endfunction

	// ==========================================
	// one frame with model update
	task automatic xfer(input logic [15:0] cmd, input logic [9:0] d);
		logic [3:0] old;
		logic [3:0] sel;
		int         sc;
		@(posedge mclk_i);
		conv_data <= d;
		aux_in    <= 4'($urandom) | pin_mask;
		old    = cur;
		sc     = scount;
		mode_a = mode_p;
		rng_a  = rng_p;
		aux_a  = aux_p;
		st_a   = st_p;
		host.frame(cmd);
		sel = st_a ? aux_in : old;
		cur = next_ch(old);
		check(16'(scount), 16'(sc + 1));
		check(16'({host.pv[12][2], host.pv[14][2], acq, host.pv[15][1], busy, sdo_oe_n,
			host.oe_bad}), 16'h003A);
		check(16'(rng), 16'(rng_a));
		if (!lax)
		begin
			check(host.rx, {sel, d, 2'b00});
			check(16'({host.pv[1][7:4], host.pv[2][7:4], mux_ch}), 16'({old, cur, cur}));
		end
		if (cmd[15:12] >= 4'h1 && cmd[15:12] <= 4'h3)
			mode_p = cmd[15:12];
		if (cmd[15:12] == 4'h1)
			man_p = cmd[10:7];
		if (cmd[15:12] == 4'h8)
			map_r = cmd[7:0];
		if (cmd[15:12] == 4'h9)
			last_r = cmd[9:6];
		if (cmd[15:12] <= 4'h3 && cmd[11])
			{rng_p, st_p, aux_p} = {cmd[6], cmd[4], cmd[3:0]};
	endtask

	// settle after a mode change, then follow the scan step by step
	task automatic scan(input logic [15:0] cmd, input int n);
		lax = 1'b1;
		repeat (3) xfer(cmd, 10'($urandom));
		cur = mux_ch;
		lax = 1'b0;
		repeat (n) xfer(cmd, 10'($urandom));
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		sys_rst_i = 1'b1;
		conv_data = 10'h000;
		aux_in    = 4'h0;
		{cur, man_p, mode_p, last_r, aux_p, pin_mask, map_r} = {4'h0, 4'h0, 4'h1, 4'h7, 8'h00, 8'hFF};
		{rng_p, st_p, lax} = 3'b000;
		void'($urandom(32'h56C4));
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		check(16'({sdo_oe_n, aux_oe_n, pwrdn, mux_ch, rng}), 16'h07C0);
		xfer(16'h1B80, 10'h3FF);
		for (int i = 0; i < 16; i++)
			xfer({4'h1, 1'($urandom), 4'($urandom % 8), 1'($urandom), 1'b0, 1'($urandom), 4'h0},
				10'($urandom));
		xfer(16'h1800, 10'h000);
		scan(16'h2000, 10);
		scan(16'h3000, 10);
		xfer({8'h80, 8'($urandom) | 8'h41}, 10'($urandom));
		xfer({6'h24, 4'($urandom % 7), 6'h00}, 10'($urandom));
		scan(16'h2000, 10);
		scan(16'h1800, 2);
		scan(16'h2000, 10);
		scan(16'h3000, 10);
		scan(16'h1800, 2);
		// aux outputs follow the data of the previous frame
		a = 4'($urandom);
		xfer(16'h400F, 10'h000);
		xfer({12'h180, a}, 10'h000);
		xfer(16'h1000, 10'h000);
		check(16'({aux_out, aux_oe_n}), 16'({a, 4'h0}));
		xfer(16'h1000, 10'h000);
		check(16'(aux_out), 16'(a));
		// high alarm on channel zero, threshold above the low codes
		xfer(16'hC810, 10'h000);
		xfer(16'h401F, 10'h000);
		xfer(16'h1000, 10'h000);
		xfer(16'h1000, 10'h3FF);
		check(16'({host.pv[11][0], host.pv[12][0], host.pv[15][0]}), 16'h0003);
		xfer(16'h1000, 10'h000);
		check(16'({host.pv[9][0], host.pv[10][0], host.pv[15][0]}), 16'h0004);
		// low alarm on channel zero, threshold above the low codes
		xfer(16'hC080, 10'h000);
		xfer(16'h1000, 10'h000);
		check(16'(aux_out[1:0]), 16'h0002);
		// power-down by command, then wake
		xfer(16'h1820, 10'h000);
		xfer(16'h1800, 10'h000);
		check(16'({host.pv[15][3], pwrdn}), 16'h0001);
		xfer(16'h1800, 10'h000);
		check(16'(pwrdn), 16'h0000);
		// pin three as power-down input
		pin_mask = 4'h8;
		xfer(16'h4020, 10'h000);
		@(posedge mclk_i);
		aux_in <= 4'h0;
		repeat (10) @(posedge mclk_i);
		check(16'(pwrdn), 16'h0001);
		aux_in <= 4'hF;
		repeat (10) @(posedge mclk_i);
		xfer(16'h1800, 10'h155);
		check(16'(pwrdn), 16'h0000);
		results();
	end
endmodule // testbench
